// *** verilog/ncb_host.sv ***
// host end of the numerics coprocessor bus: micro-op issue, operand reads,
// result collection through a FIFO. assumes all pins synchronous to clk.
`include "ncb_map.svh"
`default_nettype none

// ----------------------------------------------------------------
// result fifo
// ----------------------------------------------------------------
module ncb_fifo #(
  parameter int WIDTH = `NCB_RES_W,
  parameter int DEPTH = `NCB_FIFO_D
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("depth must be power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic             doWr;
  logic             doRd;
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;
  assign inReady  = (wrPtr[AW] == rdPtr[AW]) || (wrPtr[AW-1:0] != rdPtr[AW-1:0]);
  assign outValid = (wrPtr != rdPtr);
  assign outData  = mem[rdPtr[AW-1:0]];
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr <= '0;
    end else if (doWr) begin
      wrPtr <= wrPtr + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rdPtr <= '0;
    end else if (doRd) begin
      rdPtr <= rdPtr + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end
endmodule : ncb_fifo

// ----------------------------------------------------------------
// host controller
// ----------------------------------------------------------------
module ncb_host
  import ncb_pkg::*;
#(
  parameter int DATA_W = `NCB_DATA_W,
  parameter int TAG_W  = `NCB_TAG_W,
  parameter int DEPTH  = `NCB_FIFO_D
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  // user: micro-op issue
  input  wire logic              opValid,
  input  wire logic [`NCB_OP_W-1:0] opWord,
  output logic                   opReady,
  input  wire logic [`NCB_STAT_W-1:0] tagStatus,
  input  wire logic [`NCB_OTYP_W-1:0] outputType,
  input  wire logic              errHandshakeEn,
  // user: operand read
  input  wire logic              rdValid,
  input  wire logic [DATA_W-1:0] rdData,
  input  wire logic [TAG_W-1:0]  rdTag,
  input  wire logic              rdSpecCancel,
  output logic                   rdReady,
  // user: results
  output logic                   resValid,
  input  wire logic              resReady,
  output logic [DATA_W-1:0]      resData,
  output logic [TAG_W-1:0]       resTag,
  output logic [`NCB_TERM_W-1:0] termSeen,
  output logic                   noErrSeen,
  // pins
  output logic [`NCB_OP_W-1:0]   micro_op_bus,
  output logic [`NCB_STAT_W-1:0] tag_status_in,
  output logic [`NCB_OTYP_W-1:0] output_type_in,
  output logic                   host_read_request,
  output logic                   host_read_valid,
  input  wire logic              cop_write_request,
  input  wire logic              cop_write_valid,
  input  wire logic [`NCB_TERM_W-1:0] termination_out,
  input  wire logic              no_error_handshake,
  input  wire logic [DATA_W-1:0] shared_data_bus_i,
  output logic [DATA_W-1:0]      shared_data_bus_o,
  output logic                   shared_data_bus_oe,
  input  wire logic [TAG_W-1:0]  shared_tag_bus_i,
  output logic [TAG_W-1:0]       shared_tag_bus_o,
  output logic                   shared_tag_bus_oe
);
  if (DATA_W != `NCB_DATA_W || TAG_W != `NCB_TAG_W) begin : g_bad_width
    $error("bus widths are fixed");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rstMeta;
  logic rstN;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // ----------------------------------------------------------------
  // micro-op issue and status pins
  // ----------------------------------------------------------------
  // one op per clock at most; op and its tag travel as one word
  assign opReady = rstN;
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      micro_op_bus <= '0;
    end else begin
      micro_op_bus <= (opValid) ? opWord : '0;
    end
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tag_status_in  <= '0;
      output_type_in <= '0;
    end else begin
      tag_status_in  <= tagStatus;
      output_type_in <= errHandshakeEn ? outputType : '0;
    end
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      termSeen  <= '0;
      noErrSeen <= 1'b0;
    end else begin
      termSeen  <= termination_out;
      noErrSeen <= errHandshakeEn && no_error_handshake;
    end
  end

  // ----------------------------------------------------------------
  // arbitration: request now, own next clock
  // ----------------------------------------------------------------
  ncb_own_t owner;
  ncb_own_t next_owner;
  logic     fifoReady;
  logic     readGo;
  logic [DATA_W-1:0] heldData;
  logic [TAG_W-1:0]  heldTag;
  logic              heldCancel;
  // a read is never held off: rdReady is the internal reset, and a read request
  // wins the bus over a coprocessor write; trade-off: no back-to-back stall on reads
  assign rdReady = rstN;
  assign readGo  = rdValid && rdReady;
  always_comb begin
    if (host_read_request) begin
      next_owner = NCB_OWN_READ;
    end else if (cop_write_request && fifoReady) begin
      next_owner = NCB_OWN_COP;
    end else begin
      next_owner = NCB_OWN_HOST;
    end
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      owner <= NCB_OWN_HOST;
    end else begin
      owner <= next_owner;
    end
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      host_read_request <= 1'b0;
      heldData          <= '0;
      heldTag           <= '0;
      heldCancel        <= 1'b0;
    end else begin
      host_read_request <= readGo;
      heldData          <= rdData;
      heldTag           <= rdTag;
      heldCancel        <= rdSpecCancel;
    end
  end

  // ----------------------------------------------------------------
  // data and tag drive
  // ----------------------------------------------------------------
  // host is bus default owner, so out of reset it drives whenever coprocessor is not granted
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      host_read_valid    <= 1'b0;
      shared_data_bus_o  <= '0;
      shared_tag_bus_o   <= '0;
      shared_data_bus_oe <= 1'b0;
      shared_tag_bus_oe  <= 1'b0;
    end else begin
      host_read_valid    <= host_read_request && !heldCancel;
      shared_data_bus_o  <= host_read_request ? heldData : '0;
      shared_tag_bus_o   <= host_read_request ? heldTag : '0;
      shared_data_bus_oe <= (next_owner != NCB_OWN_COP);
      shared_tag_bus_oe  <= (next_owner != NCB_OWN_COP);
    end
  end

  // ----------------------------------------------------------------
  // result capture
  // ----------------------------------------------------------------
  logic capValid;
  // sample only in a granted clock with write valid; a dropped valid means the result is lost
  assign capValid = (owner == NCB_OWN_COP) && cop_write_valid;
  logic              fOutValid;
  logic [DATA_W+TAG_W-1:0] fOut;
  ncb_fifo #(.WIDTH(DATA_W + TAG_W), .DEPTH(DEPTH)) resFifo (
    .clk      (clk),
    .rstN     (rstN),
    .inValid  (capValid),
    .inReady  (fifoReady),
    .inData   ({shared_tag_bus_i, shared_data_bus_i}),
    .outValid (fOutValid),
    .outReady (!resValid || resReady),
    .outData  (fOut)
  );
  // fifo can go full while a grant is in flight: grant is only given when
  // ready, and one slot frees before refill only if drained; keep margin
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      resValid <= 1'b0;
      resData  <= '0;
      resTag   <= '0;
    end else if (!resValid || resReady) begin
      resValid <= fOutValid;
      resData  <= fOut[DATA_W-1:0];
      resTag   <= fOut[DATA_W+TAG_W-1:DATA_W];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  read_follow_a: assert property (@(posedge clk) disable iff (!rstN)
    host_read_valid |-> $past(host_read_request))
    else $error("read valid without request");
  read_wins_a: assert property (@(posedge clk) disable iff (!rstN)
    host_read_request && cop_write_request |=> owner == NCB_OWN_READ)
    else $error("write won over read");
  cop_owns_a: assert property (@(posedge clk) disable iff (!rstN)
    owner == NCB_OWN_COP |-> !shared_data_bus_oe && !shared_tag_bus_oe)
    else $error("host drove during coprocessor grant");
  idle_drive_a: assert property (@(posedge clk) disable iff (!rstN)
    $past(rstN) && !$past(host_read_request) && !$past(cop_write_request)
      |-> shared_data_bus_oe)
    else $error("idle bus not driven by host");
  cancel_drop_a: assert property (@(posedge clk) disable iff (!rstN)
    host_read_request && heldCancel |=> !host_read_valid)
    else $error("cancelled read marked valid");
  read_data_a: assert property (@(posedge clk) disable iff (!rstN)
    readGo |=> ##1 host_read_valid || $past(heldCancel) ##0 shared_data_bus_o == $past(rdData, 2))
    else $error("read data lost");
  read_tag_a: assert property (@(posedge clk) disable iff (!rstN)
    host_read_valid |-> shared_tag_bus_o == $past(heldTag) && shared_tag_bus_oe)
    else $error("tag does not match data");
  op_issue_a: assert property (@(posedge clk) disable iff (!rstN)
    opValid |=> micro_op_bus == $past(opWord))
    else $error("micro-op not issued");
  otyp_gate_a: assert property (@(posedge clk) disable iff (!rstN)
    !errHandshakeEn |=> output_type_in == '0)
    else $error("output type driven while disabled");
  cap_grant_a: assert property (@(posedge clk) disable iff (!rstN)
    capValid |-> $past(cop_write_request) && !$past(host_read_request))
    else $error("captured without grant");
  rd_cov: cover property (@(posedge clk) disable iff (!rstN) host_read_valid);
  wr_cov: cover property (@(posedge clk) disable iff (!rstN) capValid);
  clash_cov: cover property (@(posedge clk) disable iff (!rstN)
    host_read_request && cop_write_request);
  spec_cov: cover property (@(posedge clk) disable iff (!rstN)
    owner == NCB_OWN_COP && !cop_write_valid);
endmodule : ncb_host
`default_nettype wire

// *** verilog/ncb_map.svh ***
// constants for the host end of the numerics coprocessor bus
// assumes one clock, the coprocessor-side clock, shared with the far chip
`ifndef NCB_MAP_SVH
`define NCB_MAP_SVH
`define NCB_DATA_W    64
`define NCB_TAG_W     5
`define NCB_OP_W      16
`define NCB_STAT_W    6
`define NCB_TERM_W    2
`define NCB_OTYP_W    2
`define NCB_FIFO_D    8
`define NCB_RES_W     (`NCB_DATA_W + `NCB_TAG_W)
`endif

// *** verilog/ncb_pkg.sv ***
// types for the host end of the numerics coprocessor bus
// assumes ncb_map.svh holds the sizes
`include "ncb_map.svh"
`default_nettype none
package ncb_pkg;
  typedef enum logic [2:0] {
    NCB_OWN_HOST = 3'b001,
    NCB_OWN_READ = 3'b010,
    NCB_OWN_COP  = 3'b100
  } ncb_own_t;
endpackage : ncb_pkg
`default_nettype wire

// *** verilog/unused_placeholder_none.sv ***
`default_nettype none
`default_nettype wire

// *** bench/ncb_cop_model.sv ***
// behavioural coprocessor end of the numerics bus, driven by the bench.
// assumes write requests come from the bench and grant is judged on read priority.
`default_nettype none
module ncb_cop_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        host_read_request,
  input  wire logic        wrReq,
  input  wire logic        wrCancel,
  input  wire logic [63:0] wrData,
  input  wire logic [4:0]  wrTag,
  input  wire logic [5:0]  termIn,
  input  wire logic        noErrIn,
  output logic             cop_write_request,
  output logic             cop_write_valid,
  output logic [1:0]       termination_out,
  output logic             no_error_handshake,
  output logic [63:0]      copData,
  output logic [4:0]       copTag
);
  // ----------------------------------------
  // write arbitration
  // ----------------------------------------
  logic [63:0] heldData;
  logic [4:0]  heldTag;
  logic        heldCancel;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cop_write_request <= 1'b0;
      cop_write_valid   <= 1'b0;
    end else begin
      cop_write_request <= wrReq;
      // lost arbitration or write cancelled: valid stays low
      cop_write_valid <= cop_write_request & ~host_read_request & ~heldCancel;
    end
  end
  always_ff @(posedge clk) begin
    if (wrReq) {heldCancel, heldTag, heldData} <= {wrCancel, wrTag, wrData};
    if (cop_write_request) {copTag, copData} <= {heldTag, heldData};
  end
  // upper termination bits exist but stay unconnected
  assign termination_out    = termIn[1:0];
  assign no_error_handshake = noErrIn;
endmodule : ncb_cop_model
`default_nettype wire

// *** bench/ncb_host_tb.sv ***
// self-checking bench for the host end of the numerics coprocessor bus.
// assumes ncb_cop_model on the far side; fifo never overfilled by stimulus.
`default_nettype none
module ncb_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset_n = 1'b0, opValid = 0, errHandshakeEn = 0, rdValid = 0;
  logic rdSpecCancel = 0, resReady = 0, wrReq = 0, wrCancel = 0, noErrIn = 0;
  logic [15:0] opWord = '0;
  logic [5:0]  tagStatus = '0, termIn = '0;
  logic [1:0]  outputType = '0;
  logic [63:0] rdData = '0, wrData = '0, dataHold = '0;
  logic [4:0]  rdTag = '0, wrTag = '0, tagHold = '0;
  logic opReady, rdReady, resValid, noErrSeen, host_read_request, host_read_valid;
  logic cop_write_request, cop_write_valid, no_error_handshake, dOe, tOe;
  logic [63:0] resData, dOut, copData;
  logic [4:0]  resTag, tOut, copTag;
  logic [1:0]  termSeen, output_type_in, termination_out;
  logic [15:0] micro_op_bus;
  logic [5:0]  tag_status_in;
  wire logic [63:0] dataWire = dOe ? dOut : (cop_write_valid ? copData : ~dataHold);
  wire logic [4:0]  tagWire = tOe ? tOut : (cop_write_valid ? copTag : ~tagHold);
  int mismatches = 0, n_tests = 0;
  logic [31:0] lfsr = 32'h0B9B;
  logic [69:0] rdQ[$];
  logic [68:0] resQ[$];
  logic [26:0] prev = '0;
  logic        reqPrev = 0;
  always #25 clk = ~clk;
  ncb_host #(.DATA_W(64), .TAG_W(5), .DEPTH(8)) uut (.clk(clk), .reset_n(reset_n),
    .opValid(opValid), .opWord(opWord), .opReady(opReady), .tagStatus(tagStatus),
    .outputType(outputType), .errHandshakeEn(errHandshakeEn), .rdValid(rdValid),
    .rdData(rdData), .rdTag(rdTag), .rdSpecCancel(rdSpecCancel), .rdReady(rdReady),
    .resValid(resValid), .resReady(resReady), .resData(resData), .resTag(resTag),
    .termSeen(termSeen), .noErrSeen(noErrSeen), .micro_op_bus(micro_op_bus),
    .tag_status_in(tag_status_in), .output_type_in(output_type_in),
    .host_read_request(host_read_request), .host_read_valid(host_read_valid),
    .cop_write_request(cop_write_request), .cop_write_valid(cop_write_valid),
    .termination_out(termination_out), .no_error_handshake(no_error_handshake),
    .shared_data_bus_i(dataWire), .shared_data_bus_o(dOut), .shared_data_bus_oe(dOe),
    .shared_tag_bus_i(tagWire), .shared_tag_bus_o(tOut), .shared_tag_bus_oe(tOe));
  ncb_cop_model cop (.clk(clk), .reset_n(reset_n), .host_read_request(host_read_request),
    .wrReq(wrReq), .wrCancel(wrCancel), .wrData(wrData), .wrTag(wrTag), .termIn(termIn),
    .noErrIn(noErrIn), .cop_write_request(cop_write_request),
    .cop_write_valid(cop_write_valid), .termination_out(termination_out),
    .no_error_handshake(no_error_handshake), .copData(copData), .copTag(copTag));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], ^(lfsr & 32'h8020_0003)};
    return lfsr;
  endfunction : rnd
  task automatic check(input logic [69:0] seen, input logic [69:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // one cycle: check pins against last drive, then drive fresh values
  task automatic step(input bit rdOn, input bit wrOn, input bit cnOn, input bit wrForce);
    logic [31:0] a, b, c;
    @(posedge clk);
    #2;
    check(micro_op_bus, prev[0] ? prev[16:1] : 16'h0000);
    check(tag_status_in, prev[22:17]);
    check(output_type_in, prev[23] ? prev[25:24] : 2'b00);
    check({termSeen, noErrSeen}, {termIn[1:0], noErrIn & errHandshakeEn});
    check({opReady, rdReady}, 2'b11);
    a = rnd();
    b = rnd();
    c = rnd();
    {opValid, opWord, tagStatus, errHandshakeEn, outputType} = {a[0], b[15:0], a[6:1], a[9:7]};
    {termIn, noErrIn} = a[16:10];
    rdValid = rdOn & a[17];
    rdSpecCancel = cnOn & a[18];
    rdData = {b, c};
    rdTag = a[23:19];
    wrReq = wrOn & (a[24] | wrForce);
    wrCancel = cnOn & a[25];
    wrData = {c, b};
    wrTag = a[30:26];
    prev = {1'b0, outputType, errHandshakeEn, tagStatus, opWord, opValid};
    if (rdValid) rdQ.push_back({rdSpecCancel, rdTag, rdData});
    if (wrReq && !rdValid && !wrCancel) resQ.push_back({wrTag, wrData});
  endtask : step
  // ----------------------------------------
  // bus monitors
  // ----------------------------------------
  always @(posedge clk) begin
    dataHold <= dataWire;
    tagHold <= tagWire;
    if (reqPrev) begin
      check(host_read_valid, !rdQ[0][69]);
      if (!rdQ[0][69]) check({tagWire, dataWire, dOe}, {rdQ[0][68:0], 1'b1});
      void'(rdQ.pop_front());
    end
    if (cop_write_valid) check({dOe, tOe}, 2'b00);
    if (resValid && resReady) check({resTag, resData}, resQ.pop_front());
    reqPrev = host_read_request;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    check({host_read_request, dOe, tOe, resValid}, 4'h0);
    #2 reset_n = 1'b1;
    // internal reset copy lifts on the second edge; first capture is the third
    @(posedge clk);
    repeat (4) step(0, 0, 0, 0);
    check({dOe, tOe}, 2'b11);
    resReady = 1'b1;
    repeat (300) step(1, 1, 1, 0);
    // drain in-flight results first: the far end cannot be refused a grant
    repeat (4) step(0, 0, 0, 0);
    // queue eight results while the user stalls: seven in the fifo, one in the result register
    resReady = 1'b0;
    repeat (8) step(0, 1, 0, 1);
    repeat (4) step(0, 0, 0, 0);
    check(resValid, 1'b1);
    resReady = 1'b1;
    repeat (14) step(0, 0, 0, 0);
    check(rdQ.size() + resQ.size(), 0);
    report_and_stop();
  end
  initial begin
    #(1000 * 50);
    mismatches++;
    report_and_stop();
  end
endmodule : ncb_host_tb
`default_nettype wire
